// file: include/rsis_defs.svh
// constants for the reciprocal square root iteration step unit
// assumes inclusion by bare name from include/ on the search path
`ifndef RSIS_DEFS_SVH
`define RSIS_DEFS_SVH

// ***************************************************************
// formats and widths
// ***************************************************************
`define RSIS_SP_EXP_W 8
`define RSIS_SP_MAN_W 23
`define RSIS_DP_EXP_W 11
`define RSIS_DP_MAN_W 52
`define RSIS_SP_W 32
`define RSIS_DATA_W 64
`define RSIS_IDX_W 5
`define RSIS_EN_W 5

// ***************************************************************
// cause field positions (e v z o u i)
// ***************************************************************
`define RSIS_CAUSE_W 6
`define RSIS_EXC_E 5
`define RSIS_EXC_V 4
`define RSIS_EXC_Z 3
`define RSIS_EXC_O 2
`define RSIS_EXC_U 1
`define RSIS_EXC_I 0

// ***************************************************************
// reset values
// ***************************************************************
`define RSIS_RST_CAUSE 6'h00
`define RSIS_RST_FLAGS 5'h00
`define RSIS_RST_DATA 64'h0000000000000000
`define RSIS_RST_IDX 5'h00

`endif

// file: include/rsis_pkg.sv
// types shared by the iteration step unit and its arithmetic lanes
// assumes rsis_defs.svh is reachable on the include path
package rsis_pkg;

   // ***************************************************************
   // operand format and exception record
   // ***************************************************************
   typedef enum logic [1:0] {
      RSIS_FMT_S,
      RSIS_FMT_D,
      RSIS_FMT_PS
   } rsis_fmt_e;

   // packed in cause order, bit 5 down to bit 0
   typedef struct packed {
      logic unimpl;
      logic invalid;
      logic divzero;
      logic overflow;
      logic underflow;
      logic inexact;
   } rsis_exc_s;

endpackage

// file: include/rsis_lane_if.sv
// operand and result bundle between the step unit and one lane
// assumes rsis_pkg is compiled first
`timescale 1ns/100ps
interface rsis_lane_if #(parameter int W = 32);
   logic [W-1:0] a;
   logic [W-1:0] b;
   logic [W-1:0] res;
   rsis_pkg::rsis_exc_s exc;

   modport lane (input a, input b, output res, output exc);
   modport unit (output a, output b, input res, input exc);
endinterface

// file: hdl/rsis_lane.sv
// one iteration lane: res = (1 - a*b)/2, truncated, for one format
// assumes purely combinational use; the caller registers the result
`timescale 1ns/100ps
module rsis_lane #(
   parameter int EW = 8,
   parameter int MW = 23
) (
   rsis_lane_if.lane lif
);
   import rsis_pkg::*;

   localparam int QW = 2 * MW + 2;
   localparam int F = 3 * MW + 3;
   localparam int AW = F + MW + 5;
   localparam int BIAS = (1 << (EW - 1)) - 1;
   localparam int EMAX = (1 << EW) - 1;
   localparam int KHI = MW + 2;
   localparam int KLO = -(MW + 3);

   logic sa, sb, sp, neg, lost;
   logic [EW-1:0] ea, eb;
   logic [MW-1:0] ma, mb, man;
   logic nan_a, nan_b, inf_a, inf_b, zer_a, zer_b, den_a, den_b, snan;
   logic [QW-1:0] q;
   logic [AW-1:0] pv, one, mag, norm;
   int k, kc, excess, lead, ex;

   // ***************************************************************
   // operand classes and the wide fixed-point difference
   // ***************************************************************
   always_comb begin
      {sa, ea, ma} = lif.a;
      {sb, eb, mb} = lif.b;
      sp = sa ^ sb;
      nan_a = (ea == EW'(EMAX)) && (ma != '0);
      nan_b = (eb == EW'(EMAX)) && (mb != '0);
      inf_a = (ea == EW'(EMAX)) && (ma == '0);
      inf_b = (eb == EW'(EMAX)) && (mb == '0);
      zer_a = (ea == '0) && (ma == '0);
      zer_b = (eb == '0) && (mb == '0);
      den_a = (ea == '0) && (ma != '0);
      den_b = (eb == '0) && (mb != '0);
      snan = (nan_a && !ma[MW-1]) || (nan_b && !mb[MW-1]);
      // (RULE_01) product of the sources
      q = QW'({1'b1, ma}) * QW'({1'b1, mb});
      k = int'(ea) + int'(eb) - 2 * BIAS;
      // far out of range the smaller term (1.0 above, the product below) only feeds the sticky bits, so clamp
      kc = (k > KHI) ? KHI : ((k < KLO) ? KLO : k);
      excess = (k > KHI) ? (k - KHI) : 0;
      pv = AW'(q) << (MW + 3 + kc);
      one = AW'(1) << F;
      // (RULE_01) one minus product, sign kept apart
      if (sp) begin
         mag = one + pv;
         neg = 1'b0;
      end else if (pv > one) begin
         mag = pv - one;
         neg = 1'b1;
      end else begin
         mag = one - pv;
         neg = 1'b0;
      end
      lead = 0;
      for (int i = 0; i < AW; i++) begin
         if (mag[i]) begin
            lead = i;
         end
      end
      // (RULE_01) the minus one in the exponent halves
      ex = lead - F - 1 + excess + BIAS;
      norm = mag << (AW - 1 - lead);
      man = norm[AW-2 -: MW];
      lost = |norm[AW-MW-2:0];
   end

   // ***************************************************************
   // result and exception selection
   // ***************************************************************
   always_comb begin
      lif.exc = '0;
      lif.res = '0;
      if (den_a || den_b) begin
         // (RULE_06) denormals left to software
         lif.exc.unimpl = 1'b1;
      end else if (nan_a || nan_b || ((inf_a || inf_b) && (zer_a || zer_b))) begin
         // (RULE_06) invalid on snan or zero times inf
         lif.exc.invalid = snan || !(nan_a || nan_b);
         lif.res = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
      end else if (inf_a || inf_b) begin
         lif.res = {~sp, {EW{1'b1}}, {MW{1'b0}}};
      end else if (zer_a || zer_b) begin
         lif.res = {1'b0, EW'(BIAS - 1), {MW{1'b0}}};
      end else if (mag == '0) begin
         lif.res = '0;
      end else if (ex >= EMAX) begin
         // (RULE_06) overflow goes to infinity
         lif.exc.overflow = 1'b1;
         lif.exc.inexact = 1'b1;
         lif.res = {neg, {EW{1'b1}}, {MW{1'b0}}};
      end else if (ex <= 0) begin
         // (RULE_06) underflow flushes to zero
         lif.exc.underflow = 1'b1;
         lif.exc.inexact = 1'b1;
         lif.res = {neg, {(EW+MW){1'b0}}};
      end else begin
         // (RULE_09) truncation, rounding mode ignored
         lif.exc.inexact = lost;
         lif.res = {neg, EW'(ex), man};
      end
   end
endmodule

// file: hdl/rsis_step_unit.sv
// reciprocal square root iteration step, single, double and paired single
// assumes issue logic on clk_i presents operands for one cycle per op
//
// Overview of operation
// (RULE_01) result is negated product minus one, halved
// (RULE_02) paired single halves computed independently
// (RULE_03) bad register selections give unpredictable result
// (RULE_04) wrong first source format: unpredictable result
// (RULE_05) coprocessor unusable and reserved instruction traps
// (RULE_06) signals E, V, O, I, U; never Z
// (RULE_07) single sequence reaches 24-bit accuracy
// (RULE_08) double needs two rounds for 53 bits
// (RULE_09) accuracy and rounding implementation chosen
// (RULE_10) set cause and flags, trap when enabled
`timescale 1ns/100ps
`include "rsis_defs.svh"
module rsis_step_unit (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic issue_i,
   input wire rsis_pkg::rsis_fmt_e fmt_i,
   input wire logic [`RSIS_DATA_W-1:0] first_source_reg_i,
   input wire logic [`RSIS_DATA_W-1:0] second_source_reg_i,
   input wire logic [`RSIS_IDX_W-1:0] destination_reg_i,
   input wire logic sel_ok_i,
   input wire logic src_fmt_ok_i,
   input wire logic cop_usable_i,
   input wire logic ext_present_i,
   input wire logic [`RSIS_EN_W-1:0] trap_en_i,
   input wire logic flags_clr_i,
   output logic done_o,
   output logic wr_en_o,
   output logic [`RSIS_IDX_W-1:0] wr_idx_o,
   output logic [`RSIS_DATA_W-1:0] wr_data_o,
   output logic cu_exc_o,
   output logic ri_exc_o,
   output logic fp_trap_o,
   output logic [`RSIS_CAUSE_W-1:0] cause_o,
   output logic [`RSIS_EN_W-1:0] flags_o,
   output logic suspect_o
);
   import rsis_pkg::*;

   logic done_q, done_d;
   logic wr_en_q, wr_en_d;
   logic [`RSIS_IDX_W-1:0] wr_idx_q, wr_idx_d;
   logic [`RSIS_DATA_W-1:0] wr_data_q, wr_data_d;
   logic cu_q, cu_d;
   logic ri_q, ri_d;
   logic trap_q, trap_d;
   logic [`RSIS_CAUSE_W-1:0] cause_q, cause_d;
   logic [`RSIS_EN_W-1:0] flags_q, flags_d;
   logic suspect_q, suspect_d;

   logic go;
   rsis_exc_s exc;
   logic [`RSIS_DATA_W-1:0] res;

   // ***************************************************************
   // arithmetic lanes
   // ***************************************************************
   rsis_lane_if #(.W(`RSIS_SP_W)) lo_if ();
   rsis_lane_if #(.W(`RSIS_SP_W)) hi_if ();
   rsis_lane_if #(.W(`RSIS_DATA_W)) dp_if ();

   // (RULE_02) one lane per paired single half
   rsis_lane #(
      .EW(`RSIS_SP_EXP_W),
      .MW(`RSIS_SP_MAN_W)
   ) u_lane_lo (
      .lif(lo_if.lane)
   );

   rsis_lane #(
      .EW(`RSIS_SP_EXP_W),
      .MW(`RSIS_SP_MAN_W)
   ) u_lane_hi (
      .lif(hi_if.lane)
   );

   // (RULE_08) full double width datapath
   rsis_lane #(
      .EW(`RSIS_DP_EXP_W),
      .MW(`RSIS_DP_MAN_W)
   ) u_lane_dp (
      .lif(dp_if.lane)
   );

   // ***************************************************************
   // operand steering
   // ***************************************************************
   // all lanes see their slice every cycle; unused results are dropped
   always_comb begin
      lo_if.a = first_source_reg_i[`RSIS_SP_W-1:0];
      lo_if.b = second_source_reg_i[`RSIS_SP_W-1:0];
      hi_if.a = first_source_reg_i[`RSIS_DATA_W-1:`RSIS_SP_W];
      hi_if.b = second_source_reg_i[`RSIS_DATA_W-1:`RSIS_SP_W];
      dp_if.a = first_source_reg_i;
      dp_if.b = second_source_reg_i;
   end

   // ***************************************************************
   // result and exception merge by format
   // ***************************************************************
   always_comb begin
      res = '0;
      exc = '0;
      case (fmt_i)
         RSIS_FMT_S: begin
            // (RULE_07) single uses the low lane
            res = {{`RSIS_SP_W{1'b0}}, lo_if.res};
            exc = lo_if.exc;
         end
         RSIS_FMT_D: begin
            res = dp_if.res;
            exc = dp_if.exc;
         end
         RSIS_FMT_PS: begin
            // (RULE_02) halves placed in matching halves
            res = {hi_if.res, lo_if.res};
            exc = lo_if.exc | hi_if.exc;
         end
         default: begin
            // reserved format code: nothing implemented, trap as unimplemented
            res = '0;
            exc = '0;
            exc.unimpl = 1'b1;
         end
      endcase
      // (RULE_06) division by zero never raised
      exc.divzero = 1'b0;
   end

   // ***************************************************************
   // issue control, exceptions and status
   // ***************************************************************
   always_comb begin
      done_d = issue_i;
      // (RULE_05) coprocessor unusable has priority
      cu_d = issue_i && !cop_usable_i;
      // (RULE_05) reserved when extension absent
      ri_d = issue_i && cop_usable_i && !ext_present_i;
      go = issue_i && cop_usable_i && ext_present_i;
      // cause holds the last executed op until the next one
      cause_d = cause_q;
      trap_d = 1'b0;
      if (go) begin
         // (RULE_10) cause from this operation
         cause_d = exc;
         // (RULE_10) trap on unimplemented or enabled cause
         trap_d = exc.unimpl || ((cause_d[`RSIS_EXC_V:`RSIS_EXC_I] & trap_en_i) != '0);
      end
      // a trapping op leaves the destination alone
      wr_en_d = go && !trap_d;
      wr_idx_d = wr_idx_q;
      wr_data_d = wr_data_q;
      if (go) begin
         wr_idx_d = destination_reg_i;
         // (RULE_01) destination gets the step result
         wr_data_d = res;
      end
      // (RULE_03) no guard, result simply flagged
      // (RULE_04) first source format only flagged too
      suspect_d = go && !(sel_ok_i && src_fmt_ok_i);
      // (RULE_10) sticky flags, set beats clear
      flags_d = flags_clr_i ? '0 : flags_q;
      if (wr_en_d) begin
         flags_d = flags_d | cause_d[`RSIS_EXC_V:`RSIS_EXC_I];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         done_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_idx_q <= `RSIS_RST_IDX;
         wr_data_q <= `RSIS_RST_DATA;
         cu_q <= 1'b0;
         ri_q <= 1'b0;
         trap_q <= 1'b0;
         cause_q <= `RSIS_RST_CAUSE;
         flags_q <= `RSIS_RST_FLAGS;
         suspect_q <= 1'b0;
      end else begin
         done_q <= done_d;
         wr_en_q <= wr_en_d;
         wr_idx_q <= wr_idx_d;
         wr_data_q <= wr_data_d;
         cu_q <= cu_d;
         ri_q <= ri_d;
         trap_q <= trap_d;
         cause_q <= cause_d;
         flags_q <= flags_d;
         suspect_q <= suspect_d;
      end
   end

   // ***************************************************************
   // outputs, each straight from a flop
   // ***************************************************************
   assign done_o = done_q;
   assign wr_en_o = wr_en_q;
   assign wr_idx_o = wr_idx_q;
   assign wr_data_o = wr_data_q;
   assign cu_exc_o = cu_q;
   assign ri_exc_o = ri_q;
   assign fp_trap_o = trap_q;
   assign cause_o = cause_q;
   assign flags_o = flags_q;
   assign suspect_o = suspect_q;

endmodule

// file: test/rsis_step_unit_chk.sv
// port checker for the iteration step unit
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/100ps
`include "rsis_defs.svh"
module rsis_step_unit_chk (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic issue_i,
   input wire logic cop_usable_i,
   input wire logic ext_present_i,
   input wire logic sel_ok_i,
   input wire logic flags_clr_i,
   input wire logic [`RSIS_IDX_W-1:0] destination_reg_i,
   input wire logic done_o,
   input wire logic wr_en_o,
   input wire logic [`RSIS_IDX_W-1:0] wr_idx_o,
   input wire logic [`RSIS_DATA_W-1:0] wr_data_o,
   input wire logic cu_exc_o,
   input wire logic ri_exc_o,
   input wire logic fp_trap_o,
   input wire logic [`RSIS_CAUSE_W-1:0] cause_o,
   input wire logic [`RSIS_EN_W-1:0] flags_o,
   input wire logic suspect_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // ***************************************************************
   // answer timing and refusals
   // ***************************************************************
   ans_timing_a: assert property (issue_i |=> done_o) else $error("no done after issue");
   no_extra_a: assert property (!issue_i |=> !done_o) else $error("done without issue");
   one_answer_a: assert property (done_o |-> $onehot({wr_en_o, cu_exc_o, ri_exc_o, fp_trap_o}))
      else $error("answer not unique");
   dest_idx_a: assert property (issue_i && cop_usable_i && ext_present_i
      |=> wr_idx_o == $past(destination_reg_i)) else $error("wrong write index");
   data_hold_a: assert property (!issue_i |=> $stable(wr_data_o)) else $error("data moved");
   cu_refuse_a: assert property (issue_i && !cop_usable_i
      |=> cu_exc_o && !ri_exc_o && !wr_en_o) else $error("unusable not raised");
   ri_refuse_a: assert property (issue_i && cop_usable_i && !ext_present_i
      |=> ri_exc_o && !wr_en_o && !fp_trap_o) else $error("reserved not raised");
   suspect_sel_a: assert property (issue_i && cop_usable_i && ext_present_i && !sel_ok_i
      |=> suspect_o) else $error("suspect missing");
   // ***************************************************************
   // exception conditions
   // ***************************************************************
   no_divzero_a: assert property (!cause_o[`RSIS_EXC_Z]) else $error("divzero set");
   unimpl_trap_a: assert property (done_o && !cu_exc_o && !ri_exc_o && cause_o[`RSIS_EXC_E]
      |-> fp_trap_o && !wr_en_o) else $error("unimplemented not trapped");
   flags_sticky_a: assert property (wr_en_o |-> (flags_o & cause_o[4:0]) == cause_o[4:0])
      else $error("flag not set");
   trap_flags_a: assert property (fp_trap_o && !$past(flags_clr_i) |-> $stable(flags_o))
      else $error("flags moved on trap");
endmodule

// file: test/rsis_rf_model.sv
// register file model on the far side, takes the unit's writes
// assumes writes are one-cycle pulses on clk_i
`timescale 1ns/100ps
module rsis_rf_model (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [4:0] wr_idx_i,
   input wire logic [63:0] wr_data_i
);
   logic [63:0] mem [32];
   int wr_cnt = 0;
   // a write is only seen on the edge where the pulse stands
   always @(posedge clk_i) begin
      if (wr_en_i === 1'b1) begin
         mem[wr_idx_i] <= wr_data_i;
         wr_cnt <= wr_cnt + 1;
      end
   end
endmodule

// file: test/test_rsqrt_iteration_step_unit.sv
// self-checking bench for the iteration step unit
// assumes rsis_pkg and rsis_defs.svh compiled and on the path
`timescale 1ns/100ps
`include "rsis_defs.svh"
module test_rsqrt_iteration_step_unit;
   import rsis_pkg::*;
   logic clk_i = 0, srst_i = 1, issue_i = 0, sel_ok_i = 1, src_fmt_ok_i = 1;
   logic cop_usable_i = 1, ext_present_i = 1, flags_clr_i = 0;
   rsis_fmt_e fmt_i = RSIS_FMT_S;
   logic [63:0] first_source_reg_i = 0, second_source_reg_i = 0;
   logic [4:0] destination_reg_i = 0, trap_en_i = 0, flags_o, wr_idx_o;
   logic done_o, wr_en_o, cu_exc_o, ri_exc_o, fp_trap_o, suspect_o;
   logic [63:0] wr_data_o;
   logic [5:0] cause_o;
   int fail_count = 0, num_checks = 0;
   always #10 clk_i = ~clk_i;
   rsis_step_unit rsis_step_unit_inst (.clk_i, .srst_i, .issue_i, .fmt_i, .first_source_reg_i,
      .second_source_reg_i, .destination_reg_i, .sel_ok_i, .src_fmt_ok_i, .cop_usable_i,
      .ext_present_i, .trap_en_i, .flags_clr_i, .done_o, .wr_en_o, .wr_idx_o, .wr_data_o,
      .cu_exc_o, .ri_exc_o, .fp_trap_o, .cause_o, .flags_o, .suspect_o);
   rsis_rf_model rsis_rf_model_inst (.clk_i, .wr_en_i(wr_en_o), .wr_idx_i(wr_idx_o),
      .wr_data_i(wr_data_o));
   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic drv(input rsis_fmt_e f, input logic [63:0] a, b, input logic [4:0] d);
      @(posedge clk_i);
      issue_i <= 1;
      fmt_i <= f;
      first_source_reg_i <= a;
      second_source_reg_i <= b;
      destination_reg_i <= d;
      @(posedge clk_i);
      issue_i <= 0;
      #1;
      chk("done", 64'h1, 64'(done_o));
   endtask
   // executed op: result, cause and the far side's copy
   task automatic op(input rsis_fmt_e f, input logic [63:0] a, b, input logic [4:0] d,
         input logic [63:0] e, input logic [5:0] c);
      drv(f, a, b, d);
      chk("wr_en", 64'h1, 64'(wr_en_o));
      chk("data", e, wr_data_o);
      chk("cause", 64'(c), 64'(cause_o));
      @(posedge clk_i);
      #1;
      chk("rf", e, rsis_rf_model_inst.mem[d]);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_basic();
      op(RSIS_FMT_S, 64'h3f800000, 64'h3f800000, 5'h01, 64'h0, 6'h00);
      op(RSIS_FMT_S, 64'h40400000, 64'h3f800000, 5'h1f, 64'hbf800000, 6'h00);
      op(RSIS_FMT_S, 64'h3f800000, 64'h0, 5'h02, 64'h3f000000, 6'h00);
      op(RSIS_FMT_D, 64'h3ff0000000000000, 64'h0, 5'h03, 64'h3fe0000000000000, 6'h00);
      op(RSIS_FMT_D, 64'h4008000000000000, 64'h3ff0000000000000, 5'h0e,
         64'hbff0000000000000, 6'h00);
      op(RSIS_FMT_S, 64'h40000000, 64'h3e800000, 5'h10, 64'h3e800000, 6'h00);
   endtask
   task automatic t_paired();
      op(RSIS_FMT_PS, 64'h404000003f800000, 64'h3f8000003f800000, 5'h04,
         64'hbf80000000000000, 6'h00);
      op(RSIS_FMT_PS, 64'h3f80000040400000, 64'h3f8000003f800000, 5'h05,
         64'h00000000bf800000, 6'h00);
   endtask
   task automatic t_excs();
      op(RSIS_FMT_S, 64'h7f800001, 64'h3f800000, 5'h06, 64'h7fc00000, 6'h10);
      chk("flags", 64'h10, 64'(flags_o));
      op(RSIS_FMT_S, 64'h7f000000, 64'h7f000000, 5'h07, 64'hff800000, 6'h05);
      chk("flags", 64'h15, 64'(flags_o));
      // lost bits below the mantissa are dropped, not rounded
      op(RSIS_FMT_S, 64'h3f800001, 64'h3f800001, 5'h12, 64'hb4000000, 6'h01);
      flags_clr_i <= 1;
      @(posedge clk_i);
      flags_clr_i <= 0;
      #1;
      chk("flags", 64'h0, 64'(flags_o));
   endtask
   task automatic t_trap();
      int n;
      n = rsis_rf_model_inst.wr_cnt;
      trap_en_i <= 5'h10;
      drv(RSIS_FMT_S, 64'h7f800001, 64'h3f800000, 5'h08);
      chk("trap", 64'h2, 64'({fp_trap_o, wr_en_o}));
      chk("cause", 64'h10, 64'(cause_o));
      chk("flags", 64'h0, 64'(flags_o));
      trap_en_i <= 5'h00;
      drv(RSIS_FMT_S, 64'h00000001, 64'h3f800000, 5'h09);
      chk("trap", 64'h2, 64'({fp_trap_o, wr_en_o}));
      chk("cause", 64'h20, 64'(cause_o));
      drv(rsis_fmt_e'(2'h3), 64'h3f800000, 64'h3f800000, 5'h0a);
      chk("trap", 64'h2, 64'({fp_trap_o, wr_en_o}));
      @(posedge clk_i);
      chk("writes", 64'(n), 64'(rsis_rf_model_inst.wr_cnt));
   endtask
   task automatic t_refuse();
      cop_usable_i <= 0;
      // nonzero result here, but the second op's zero result would overwrite a refused write before the data check
      drv(RSIS_FMT_S, 64'h40400000, 64'h3f800000, 5'h0b);
      chk("cu", 64'h4, 64'({cu_exc_o, ri_exc_o, wr_en_o}));
      ext_present_i <= 0;
      drv(RSIS_FMT_S, 64'h3f800000, 64'h3f800000, 5'h0b);
      chk("cu", 64'h4, 64'({cu_exc_o, ri_exc_o, wr_en_o}));
      cop_usable_i <= 1;
      drv(RSIS_FMT_D, 64'h3f800000, 64'h3f800000, 5'h0b);
      chk("ri", 64'h2, 64'({cu_exc_o, ri_exc_o, wr_en_o}));
      chk("data", 64'h0, wr_data_o);
      ext_present_i <= 1;
   endtask
   task automatic t_suspect();
      sel_ok_i <= 0;
      drv(RSIS_FMT_S, 64'h3f800000, 64'h3f800000, 5'h0c);
      chk("suspect", 64'h3, 64'({suspect_o, wr_en_o}));
      sel_ok_i <= 1;
      src_fmt_ok_i <= 0;
      drv(RSIS_FMT_S, 64'h3f800000, 64'h3f800000, 5'h0d);
      chk("suspect", 64'h3, 64'({suspect_o, wr_en_o}));
      src_fmt_ok_i <= 1;
   endtask
   // mid-run reset drops the result, status, done, write, trap and suspect outputs
   task automatic t_reset();
      op(RSIS_FMT_S, 64'h7f000000, 64'h7f000000, 5'h11, 64'hff800000, 6'h05);
      srst_i <= 1;
      repeat (2) @(posedge clk_i);
      srst_i <= 0;
      #1;
      chk("rst_data", 64'h0, wr_data_o);
      chk("rst_status", 64'h0, 64'({cause_o, flags_o, wr_idx_o}));
      chk("rst_pulse", 64'h0, 64'({done_o, wr_en_o, fp_trap_o, suspect_o}));
   endtask
   // back to back: a new op on every edge, each answered one cycle on
   task automatic t_b2b();
      @(posedge clk_i);
      issue_i <= 1;
      first_source_reg_i <= 64'h40400000;
      second_source_reg_i <= 64'h3f800000;
      @(posedge clk_i);
      first_source_reg_i <= 64'h3f800000;
      #1;
      chk("data", 64'hbf800000, wr_data_o);
      @(posedge clk_i);
      issue_i <= 0;
      #1;
      chk("data", 64'h0, wr_data_o);
      chk("done", 64'h1, 64'(done_o));
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 0;
      t_basic();
      t_paired();
      t_excs();
      t_trap();
      t_refuse();
      t_suspect();
      t_reset();
      t_b2b();
      finish_test();
   end
   // tests take well under 200 cycles
   initial begin
      repeat (2000) @(posedge clk_i);
      fail_count++;
      finish_test();
   end
endmodule
bind rsis_step_unit rsis_step_unit_chk rsis_step_unit_chk_inst (.clk_i, .srst_i, .issue_i,
   .cop_usable_i, .ext_present_i, .sel_ok_i, .flags_clr_i, .destination_reg_i, .done_o,
   .wr_en_o, .wr_idx_o, .wr_data_o, .cu_exc_o, .ri_exc_o, .fp_trap_o, .cause_o, .flags_o,
   .suspect_o);
